// ---- irq_prio_pkg.sv ----
package irq_prio_pkg;

	// register map
	localparam logic [11:0] PRIO_TWO_OFFSET = 12'h000;
	localparam logic [11:0] PRIO_LEVELS_OFFSET = 12'h004;
	localparam logic [7:0] PRIO_TWO_RESET = 8'h00;
	localparam logic [7:0] PRIO_TWO_WMASK = 8'h5F;

	// field positions
	localparam int TIMER_THREE_POS = 0;
	localparam int ADC0_DONE_POS = 1;
	localparam int TIMER_FOUR_POS = 2;
	localparam int ADC2_WINDOW_POS = 3;
	localparam int ADC2_DONE_POS = 4;
	localparam int UART1_POS = 6;

	// one bit per source: 0 low, 1 high
	typedef struct packed {
		logic unused7;
		logic uart1_irq_priority;
		logic unused5;
		logic adc2_done_irq_priority;
		logic adc2_window_irq_priority;
		logic timer_four_irq_priority;
		logic adc0_done_irq_priority;
		logic timer_three_irq_priority;
	} prio_levels_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_resp_t;

endpackage

// ---- prio_field.sv ----
`timescale 1ns/1ps
module prio_field
	import irq_prio_pkg::*;
#(
	parameter logic [7:0] WMASK = PRIO_TWO_WMASK
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// write port
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	// stored value
	output logic [7:0] value_q
);

	logic [7:0] value_d;

	// unused bits stay zero
	assign value_d = wr_en ? (wr_data & WMASK) : value_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_q <= PRIO_TWO_RESET;
		end else begin
			value_q <= value_d;
		end
	end

endmodule

// ---- extended_irq_priority_two.sv ----
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module extended_irq_priority_two
	import irq_prio_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// per-source priority levels
	output prio_levels_t prio_q
);

	logic [7:0] reg_q;
	logic wr_en;
	logic access;
	logic hit_reg;
	logic hit_lvl;
	apb_resp_t resp_q;
	apb_resp_t resp_d;
	prio_levels_t prio_d;

	assign access = psel && penable && !resp_q.pready;
	assign hit_reg = paddr == PRIO_TWO_OFFSET;
	assign hit_lvl = paddr == PRIO_LEVELS_OFFSET;
	assign wr_en = access && pwrite && hit_reg && pstrb[0];

	prio_field #(
		.WMASK(PRIO_TWO_WMASK)
	) u_field (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_en),
		.wr_data(pwdata[7:0]),
		.value_q(reg_q)
	);

	// one wait state, then answer
	always_comb begin
		resp_d = '0;
		if (access) begin
			resp_d.pready = 1'b1;
			resp_d.pslverr = !(hit_reg || (hit_lvl && !pwrite));
			if (!pwrite && (hit_reg || hit_lvl)) begin
				resp_d.prdata = {24'h000000, reg_q};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_q <= '0;
		end else begin
			resp_q <= resp_d;
		end
	end

	assign prdata = resp_q.prdata;
	assign pready = resp_q.pready;
	assign pslverr = resp_q.pslverr;

	always_comb begin
		prio_d = '0;
		prio_d.adc2_done_irq_priority = reg_q[ADC2_DONE_POS];
		prio_d.adc2_window_irq_priority = reg_q[ADC2_WINDOW_POS];
		prio_d.timer_four_irq_priority = reg_q[TIMER_FOUR_POS];
		prio_d.adc0_done_irq_priority = reg_q[ADC0_DONE_POS];
		prio_d.timer_three_irq_priority = reg_q[TIMER_THREE_POS];
		prio_d.uart1_irq_priority = reg_q[UART1_POS];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prio_q <= '0;
		end else begin
			prio_q <= prio_d;
		end
	end

	AST_ADC2_DONE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en |-> ##2 prio_q.adc2_done_irq_priority == $past(pwdata[4], 2))
		else $error("adc2 done level wrong");
	AST_ADC2_WIN: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en |-> ##2 prio_q.adc2_window_irq_priority == $past(pwdata[3], 2))
		else $error("adc2 window level wrong");
	AST_TIMER_FOUR: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en |-> ##2 prio_q.timer_four_irq_priority == $past(pwdata[2], 2))
		else $error("timer four level wrong");
	AST_ADC0_DONE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en |-> ##2 prio_q.adc0_done_irq_priority == $past(pwdata[1], 2))
		else $error("adc0 done level wrong");
	AST_TIMER_THREE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en |-> ##2 prio_q.timer_three_irq_priority == $past(pwdata[0], 2))
		else $error("timer three level wrong");
	AST_UART1: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en |-> ##2 prio_q.uart1_irq_priority == $past(pwdata[6], 2))
		else $error("uart1 level wrong");
	AST_UNUSED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		pready && !pslverr |-> prdata[7] == 1'b0 && prdata[5] == 1'b0
			&& prdata[31:8] == 24'h000000)
		else $error("unused bits read nonzero");
	AST_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable ##1 psel && penable |-> ##1 pready ##1 !pready)
		else $error("apb answer timing wrong");

	AST_ADC2_DONE_STEADY: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_en |-> ##2 $stable(prio_q.adc2_done_irq_priority))
		else $error("adc2 done level moved without write");

	AST_ADC2_WIN_STEADY: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_en |-> ##2 $stable(prio_q.adc2_window_irq_priority))
		else $error("adc2 window level moved without write");

	AST_TIMER_FOUR_STEADY: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_en |-> ##2 $stable(prio_q.timer_four_irq_priority))
		else $error("timer four level moved without write");

	AST_ADC0_DONE_STEADY: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_en |-> ##2 $stable(prio_q.adc0_done_irq_priority))
		else $error("adc0 done level moved without write");

	AST_TIMER_THREE_STEADY: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_en |-> ##2 $stable(prio_q.timer_three_irq_priority))
		else $error("timer three level moved without write");

	AST_UART1_STEADY: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_en |-> ##2 $stable(prio_q.uart1_irq_priority))
		else $error("uart1 level moved without write");

	AST_UNUSED7_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		prio_q.unused7 == 1'b0)
		else $error("spare level bit seven set");

	AST_UNUSED5_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		prio_q.unused5 == 1'b0)
		else $error("spare level bit five set");

	AST_REG_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
		(reg_q & ~PRIO_TWO_WMASK) == 8'h00)
		else $error("spare register bit set");

	AST_HOLD_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_en |=> reg_q == $past(reg_q))
		else $error("register changed without write");

	AST_WRITE_STORES: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en |=> reg_q == ($past(pwdata[7:0]) & PRIO_TWO_WMASK))
		else $error("write not stored");

	AST_STROBE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		access && pwrite && hit_reg && !pstrb[0] |=> reg_q == $past(reg_q))
		else $error("write without byte strobe landed");

	AST_NO_WRITE_ON_ERR: assert property (@(posedge pclk) disable iff (!presetn)
		access && pwrite && !hit_reg |=> reg_q == $past(reg_q))
		else $error("refused write changed register");

	AST_READ_OK: assert property (@(posedge pclk) disable iff (!presetn)
		access && !pwrite && hit_reg |=> pready && !pslverr && prdata == {24'h000000, $past(reg_q)})
		else $error("register read answer wrong");

	AST_MIRROR_READ: assert property (@(posedge pclk) disable iff (!presetn)
		access && !pwrite && hit_lvl |=> pready && !pslverr && prdata == {24'h000000, $past(reg_q)})
		else $error("mirror read answer wrong");

	AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
		access && !hit_reg && !hit_lvl |=> pready && pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");

	AST_ERR_MIRROR_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		access && pwrite && hit_lvl |=> pready && pslverr)
		else $error("mirror write not refused");

	AST_WRITE_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		access && pwrite |=> prdata == 32'h00000000)
		else $error("write answer carries data");

	AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	AST_PREADY_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> $past(psel && penable))
		else $error("ready without access");

	AST_READY_AFTER_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
		access |=> pready)
		else $error("access not answered");

	AST_NO_READY_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		!psel |=> !pready)
		else $error("ready while bus idle");

	AST_IDLE_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h00000000 && !pslverr)
		else $error("answer outputs set outside ready");

	AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error without ready");

	AST_READ_ERR_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> prdata == 32'h00000000)
		else $error("error answer carries data");

	AST_PRDATA_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
		prdata[31:8] == 24'h000000)
		else $error("upper read bits set");

	AST_RESET_REG: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> reg_q == PRIO_TWO_RESET)
		else $error("register not cleared by reset");

	AST_RESET_LEVELS: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> prio_q == 8'h00)
		else $error("levels not low after reset");

	AST_RESET_BUS: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> !pready && !pslverr && prdata == 32'h00000000)
		else $error("bus answer not idle after reset");

	// each level bit tracks its register bit
	for (genvar i = 0; i < 8; i++) begin : gen_lvl
		if (PRIO_TWO_WMASK[i]) begin : gen_kept
			AST_BIT_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
				1'b1 |=> prio_q[i] == $past(reg_q[i]))
				else $error("level bit does not follow register");
		end else begin : gen_spare
			AST_BIT_SPARE: assert property (@(posedge pclk) disable iff (!presetn)
				prio_q[i] == 1'b0)
				else $error("spare level bit set");
		end
	end

endmodule

// ---- extended_irq_priority_two_test.sv ----
`timescale 1ns/1ps
module extended_irq_priority_two_test;
	import irq_prio_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	prio_levels_t prio_q;
	int n_errors, checked;
	extended_irq_priority_two dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.prio_q(prio_q));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic report_and_stop();
		$display("checked %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, entered and left just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			n_errors++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// write, then check levels, register and mirror
	task automatic wchk(input logic [31:0] d, input logic [3:0] s, input logic [7:0] e);
		apb(1'b1, PRIO_TWO_OFFSET, d, s);
		cmp({31'h0, err}, 32'h0);
		cmp({24'h0, prio_q}, {24'h0, e});
		apb(1'b0, PRIO_TWO_OFFSET, 32'h0, 4'hF);
		cmp(rd, {24'h0, e});
		apb(1'b0, PRIO_LEVELS_OFFSET, 32'h0, 4'hF);
		cmp(rd, {24'h0, e});
	endtask
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		n_errors = 0;
		checked = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, PRIO_TWO_OFFSET, 32'h0, 4'hF);
		cmp(rd, {24'h0, PRIO_TWO_RESET});
		cmp({24'h0, prio_q}, 32'h0);
		$display("test reset done");
		for (int b = 0; b < 8; b++) begin
			wchk(32'h1 << b, 4'hF, 8'(1 << b) & PRIO_TWO_WMASK);
		end
		wchk(32'hFFFF_FFFF, 4'hF, 8'h5F);
		wchk(32'h0000_0000, 4'hF, 8'h00);
		wchk(32'h0000_00FF, 4'h0, 8'h00);
		$display("test fields done");
		wchk(32'h0000_0015, 4'h1, 8'h15);
		apb(1'b1, PRIO_LEVELS_OFFSET, 32'h0000_000A, 4'hF);
		cmp({31'h0, err}, 32'h1);
		apb(1'b0, PRIO_TWO_OFFSET, 32'h0, 4'hF);
		cmp(rd, 32'h0000_0015);
		apb(1'b0, 12'h010, 32'h0, 4'hF);
		cmp({err, rd[30:0]}, 32'h8000_0000);
		wchk(32'h0000_0015, 4'h1, 8'h15);
		$display("test errors done");
		wchk(32'h0000_005F, 4'hF, 8'h5F);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		cmp({24'h0, prio_q}, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, PRIO_TWO_OFFSET, 32'h0, 4'hF);
		cmp(rd, {24'h0, PRIO_TWO_RESET});
		$display("test mid reset done");
		report_and_stop();
	end
endmodule
